// ==== verilog/esr_pkg.sv ====
// Shared constants and types for the engine speed reference ramp
`default_nettype none
package esr_pkg;
  // Control clock rate and ramp update period
  localparam int unsigned CLK_MHZ  = 125;
  localparam int unsigned TICK_US  = 1000;
  localparam int unsigned TICK_CYC = TICK_US * CLK_MHZ;
  // Speed word width and sensor count
  localparam int unsigned SPD_W    = 16;
  localparam int unsigned NSENS    = 2;
  // Sensor failure threshold as a percentage of rated speed
  localparam logic [7:0] FAIL_PCT  = 8'h05;
  localparam logic [7:0] FULL_PCT  = 8'h64;
  // Remote loop current thresholds in microamps
  localparam logic [15:0] UA_FAIL_LO = 16'h07d0;  // 2 mA
  localparam logic [15:0] UA_FAIL_HI = 16'h5208;  // 21 mA
  localparam logic [15:0] UA_SPAN_LO = 16'h0fa0;  // 4 mA
  localparam logic [15:0] UA_SPAN_HI = 16'h4e20;  // 20 mA
  // Reference selector states
  typedef enum logic [4:0] {
    ST_START  = 5'b00001,
    ST_IDLE   = 5'b00010,
    ST_ACCEL  = 5'b00100,
    ST_RATED  = 5'b01000,
    ST_REMOTE = 5'b10000
  } esr_state_e;
endpackage : esr_pkg
`default_nettype wire

// ==== verilog/esr_slew_if.sv ====
// Bundle between the selector and the saturating slew stage
`timescale 1ns/1ps
`default_nettype none
interface esr_slew_if;
  logic [esr_pkg::SPD_W-1:0] cur;
  logic [esr_pkg::SPD_W-1:0] target;
  logic [esr_pkg::SPD_W-1:0] up_step;
  logic [esr_pkg::SPD_W-1:0] dn_step;
  logic [esr_pkg::SPD_W-1:0] lo;
  logic [esr_pkg::SPD_W-1:0] hi;
  logic [esr_pkg::SPD_W-1:0] nxt;
  modport user (output cur, target, up_step, dn_step, lo, hi,
                input nxt);
  modport slew (input cur, target, up_step, dn_step, lo, hi,
                output nxt);
endinterface : esr_slew_if
`default_nettype wire

// ==== verilog/esr_slew.sv ====
// Saturating one-step slew toward a clamped target
`timescale 1ns/1ps
`default_nettype none
module esr_slew (
  esr_slew_if.slew s  // Current value, target, steps and limits
);
  logic [esr_pkg::SPD_W-1:0] tgt;

  // Clamp the target into the window, then step without overshoot
  always_comb begin
    tgt = s.target;
    if (tgt < s.lo)
      tgt = s.lo;
    if (tgt > s.hi)
      tgt = s.hi;
    s.nxt = tgt;
    if (tgt > s.cur && (tgt - s.cur) > s.up_step)
      s.nxt = s.cur + s.up_step;
    else if (tgt < s.cur && (s.cur - tgt) > s.dn_step)
      s.nxt = s.cur - s.dn_step;
  end
endmodule : esr_slew
`default_nettype wire

// ==== verilog/esr_ramp.sv ====
// Speed reference selector, ramp, sensor and alarm-reset logic
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Sensor below five percent rated flags failure
// - One failed sensor disables torsional filter
// - Both failed: zero fuel unless override
// - Reset pulse clears latches now valid
// - Reset input true-then-false makes pulse
// - Reset pulse at power-up and optional startup
// - Local raise/lower only without remote
// - Analog remote needs raise,lower,rated, no net
// - Network reference needs raise,lower,rated, net
// - Accel/decel size ramps; rates size raise/lower
// - Start reference off unless configured
// - Start reference overrides until engine passes it
// - Rated open targets idle
// - Rated closed ramps idle to rated
// - Raise/lower cancels accel; then clamped moves
// - Remote selected at rated tracks remote value
// - Remote selected during accel tracks remote
// - Below 2 or above 21 mA is fault
// - Linear 4-20 mA map, either direction
// - Track remote at rates within limits
// - Fault holds if hold-last, else tracks
// - Rated to idle ramps at decel
module esr_ramp #(
  parameter int unsigned TICK_CYC = esr_pkg::TICK_CYC  // Cycles a tick
) (
  input  wire logic              clk,          // 125 MHz clock
  input  wire logic              nrst,         // Sync reset, low
  input  wire logic              raise_in,     // Raise contact pin
  input  wire logic              lower_in,     // Lower contact pin
  input  wire logic              rated_in,     // Idle/rated pin
  input  wire logic              alm_rst_in,   // Alarm reset pin
  input  wire logic              spd_ovrd_in,  // Speed fail override
  input  wire logic              net_sel_in,   // Network ref select
  input  wire logic [15:0]       spd_a,        // Sensor A speed
  input  wire logic [15:0]       spd_b,        // Sensor B speed
  input  wire logic [15:0]       rem_ua,       // Remote loop, uA
  input  wire logic [15:0]       network_analog_write_value, // Net ref
  input  wire logic              net_link_err, // Network link error
  input  wire logic              cfg_start_en, // Use start reference
  input  wire logic              cfg_rst_start,// Reset on startup
  input  wire logic              cfg_tors_en,  // Torsional filter on
  input  wire logic              cfg_hold_last,// Hold on fault
  input  wire logic              selftest_ok,  // Self-test passed
  input  wire logic [15:0]       start_sp,     // Start speed
  input  wire logic [15:0]       idle_sp,      // Idle speed
  input  wire logic [15:0]       rated_sp,     // Rated speed
  input  wire logic [15:0]       low_lim,      // Lower limit
  input  wire logic [15:0]       raise_lim,    // Raise limit
  input  wire logic [15:0]       accel_step,   // Accel step a tick
  input  wire logic [15:0]       decel_step,   // Decel step a tick
  input  wire logic [15:0]       raise_rate,   // Raise step a tick
  input  wire logic [15:0]       lower_rate,   // Lower step a tick
  input  wire logic [15:0]       rem_sp_4ma,   // Speed at 4 mA
  input  wire logic [15:0]       rem_sp_20ma,  // Speed at 20 mA
  input  wire logic [15:0]       net_default,  // Net default value
  output logic      [15:0]       speed_ref,    // Speed reference
  output logic      [1:0]        sens_bad,     // Live sensor fail
  output logic      [1:0]        sens_flt,     // Latched sensor fail
  output logic                   rem_flt,      // Latched remote fault
  output logic                   tors_en,      // Torsional filter on
  output logic                   fuel_zero,    // Force fuel to zero
  output logic                   fuel_max_ok,  // Fuel allowed to max
  output logic                   alm_pulse,    // Alarm reset pulse
  output logic                   rem_active,   // Remote tracking
  output logic      [4:0]        ref_state     // Selector state
);
  localparam int unsigned CW = $clog2(TICK_CYC + 1);
  localparam logic [CW-1:0] TICK_LAST = CW'(TICK_CYC - 1);
  localparam logic [15:0] SPAN_UA =
    esr_pkg::UA_SPAN_HI - esr_pkg::UA_SPAN_LO;
  localparam logic [15:0] SPD_MAX = 16'hffff;
  localparam logic [15:0] SPD_ZERO = 16'h0000;

  typedef enum logic [2:0] {PIN_RAISE = 3'h0, PIN_LOWER = 3'h1,
    PIN_RATED = 3'h2, PIN_ALM = 3'h3, PIN_OVRD = 3'h4,
    PIN_NET = 3'h5} esr_pin_e;

  esr_pkg::esr_state_e st;
  esr_pkg::esr_state_e next_st;
  logic [5:0]    pin_m;
  logic [5:0]    pin_s;
  logic          alm_q;
  logic          por_pend;
  logic          run_q;
  logic [CW-1:0] tick_cnt;
  logic          tick;
  logic [15:0]   spd [esr_pkg::NSENS];
  logic [1:0]    fail_now;
  logic [15:0]   eng_spd;
  logic          running;
  logic          rem_sel;
  logic          ana_en;
  logic          net_en;
  logic          loc_raise;
  logic          loc_lower;
  logic          ana_bad;
  logic          rem_bad;
  logic [15:0]   ua_use;
  logic signed [33:0] map_prod;
  logic signed [33:0] map_sum;
  logic [15:0]   ana_spd;
  logic [15:0]   rem_tgt;
  logic [15:0]   ref_q;

  esr_slew_if sl ();

  esr_slew u_slew (
    .s (sl.slew)
  );

  // Contact pins cross in through two flops; only the second is read
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_m <= 6'h00;
      pin_s <= 6'h00;
    end else begin
      pin_m <= {net_sel_in, spd_ovrd_in, alm_rst_in, rated_in,
                lower_in, raise_in};
      pin_s <= pin_m;
    end
  end

  // Free-running control tick paces the ramp
  always_ff @(posedge clk) begin
    if (!nrst)
      tick_cnt <= '0;
    else if (tick_cnt == TICK_LAST)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + 1'b1;
  end
  assign tick = (tick_cnt == TICK_LAST);

  assign spd[0] = spd_a;
  assign spd[1] = spd_b;

  // Per-sensor failure test, compared in scaled form to avoid a divide
  for (genvar g = 0; g < esr_pkg::NSENS; g++) begin : g_sens
    assign fail_now[g] = (24'(spd[g]) * 24'(esr_pkg::FULL_PCT)) <
                         (24'(rated_sp) * 24'(esr_pkg::FAIL_PCT));
  end

  // High signal select of the two sensors
  assign eng_spd = (spd_a > spd_b) ? spd_a : spd_b;
  assign running = ~(sens_bad[0] & sens_bad[1]);

  assign rem_sel = pin_s[PIN_RAISE] & pin_s[PIN_LOWER] &
                   pin_s[PIN_RATED];
  assign ana_en  = rem_sel & ~pin_s[PIN_NET];
  assign net_en  = rem_sel & pin_s[PIN_NET];
  // local commands locked out by remote
  assign loc_raise = pin_s[PIN_RAISE] & ~pin_s[PIN_LOWER] & ~rem_sel;
  assign loc_lower = pin_s[PIN_LOWER] & ~pin_s[PIN_RAISE] & ~rem_sel;

  assign ana_bad = (rem_ua < esr_pkg::UA_FAIL_LO) |
                   (rem_ua > esr_pkg::UA_FAIL_HI);
  assign rem_bad = (ana_en & ana_bad) | (net_en & net_link_err);

  // Healthy input clamps to the span; a faulty one is followed raw
  always_comb begin
    ua_use = rem_ua;
    if (!ana_bad && rem_ua < esr_pkg::UA_SPAN_LO)
      ua_use = esr_pkg::UA_SPAN_LO;
    if (!ana_bad && rem_ua > esr_pkg::UA_SPAN_HI)
      ua_use = esr_pkg::UA_SPAN_HI;
  end

  // straight line through both end points, signed for reverse
  always_comb begin
    map_prod = (34'(signed'({1'b0, ua_use})) -
                34'(signed'({1'b0, esr_pkg::UA_SPAN_LO}))) *
               (34'(signed'({1'b0, rem_sp_20ma})) -
                34'(signed'({1'b0, rem_sp_4ma})));
    map_sum = map_prod / 34'(signed'({1'b0, SPAN_UA})) +
              34'(signed'({1'b0, rem_sp_4ma}));
    if (map_sum < 0)
      ana_spd = SPD_ZERO;
    else if (map_sum > 34'(signed'({1'b0, SPD_MAX})))
      ana_spd = SPD_MAX;
    else
      ana_spd = map_sum[15:0];
  end

  // hold or follow on a faulty remote source
  always_comb begin
    if (rem_bad && cfg_hold_last)
      rem_tgt = ref_q;
    else if (net_en)
      rem_tgt = net_link_err ? net_default : network_analog_write_value;
    else
      rem_tgt = ana_spd;
  end

  // Reference selector transitions
  always_comb begin
    next_st = st;
    case (st)
      esr_pkg::ST_START: begin
        if (!cfg_start_en || eng_spd > start_sp)
          // leave start once engine passes it
          next_st = pin_s[PIN_RATED] ? esr_pkg::ST_ACCEL
                                     : esr_pkg::ST_IDLE;
      end
      esr_pkg::ST_IDLE: begin
        // rated closed begins the accel ramp
        if (pin_s[PIN_RATED])
          // remote picked up as rated closes
          next_st = rem_sel ? esr_pkg::ST_REMOTE : esr_pkg::ST_ACCEL;
      end
      esr_pkg::ST_ACCEL: begin
        if (!pin_s[PIN_RATED])
          next_st = esr_pkg::ST_IDLE;
        else if (rem_sel)
          next_st = esr_pkg::ST_REMOTE;
        // raise or lower cancels the ramp
        else if (loc_raise || loc_lower || ref_q == rated_sp)
          next_st = esr_pkg::ST_RATED;
      end
      esr_pkg::ST_RATED: begin
        if (!pin_s[PIN_RATED])
          next_st = esr_pkg::ST_IDLE;
        else if (rem_sel)
          next_st = esr_pkg::ST_REMOTE;
      end
      esr_pkg::ST_REMOTE: begin
        if (!pin_s[PIN_RATED])
          next_st = esr_pkg::ST_IDLE;
        else if (!rem_sel)
          next_st = esr_pkg::ST_RATED;
      end
      default: next_st = esr_pkg::ST_START;
    endcase
    // a stopped engine re-selects the start reference
    if (cfg_start_en && !running)
      next_st = esr_pkg::ST_START;
  end

  always_ff @(posedge clk) begin
    if (!nrst)
      st <= esr_pkg::ST_START;
    else
      st <= next_st;
  end

  // Slew stage set-up per state; idle may sit below the lower limit
  always_comb begin
    sl.cur     = ref_q;
    sl.target  = ref_q;
    sl.up_step = SPD_ZERO;
    sl.dn_step = SPD_ZERO;
    sl.lo      = SPD_ZERO;
    sl.hi      = SPD_MAX;
    case (st)
      esr_pkg::ST_IDLE: begin
        // idle target; accel up, decel down
        sl.target  = idle_sp;
        sl.up_step = accel_step;
        // decel time sizes the drop to idle
        sl.dn_step = decel_step;
      end
      esr_pkg::ST_ACCEL: begin
        // accel time sizes idle to rated
        sl.target  = rated_sp;
        sl.up_step = accel_step;
        sl.dn_step = accel_step;
      end
      esr_pkg::ST_RATED: begin
        // raise and lower clamped to limits
        sl.target  = loc_raise ? raise_lim :
                     loc_lower ? low_lim : ref_q;
        sl.up_step = raise_rate;
        sl.dn_step = lower_rate;
        sl.lo      = low_lim;
        sl.hi      = raise_lim;
      end
      esr_pkg::ST_REMOTE: begin
        // track remote at rates inside limits
        sl.target  = rem_tgt;
        sl.up_step = raise_rate;
        sl.dn_step = lower_rate;
        sl.lo      = low_lim;
        sl.hi      = raise_lim;
      end
      default: sl.target = ref_q;
    endcase
  end

  // Reference register: start value jumps in, all else steps a tick
  always_ff @(posedge clk) begin
    if (!nrst)
      ref_q <= SPD_ZERO;
    else if (st == esr_pkg::ST_START && cfg_start_en)
      ref_q <= start_sp;
    else if (tick)
      ref_q <= sl.nxt;
  end

  // Alarm reset: falling input edge, power-up and optional startup
  always_ff @(posedge clk) begin
    if (!nrst) begin
      alm_q     <= 1'b0;
      por_pend  <= 1'b1;
      run_q     <= 1'b0;
      alm_pulse <= 1'b0;
    end else begin
      alm_q    <= pin_s[PIN_ALM];
      por_pend <= 1'b0;
      run_q    <= running;
      // true then false; power-up and startup
      alm_pulse <= (alm_q & ~pin_s[PIN_ALM]) | por_pend |
                   (cfg_rst_start & running & ~run_q);
    end
  end

  // Latched failures; a new failure beats a reset in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sens_bad <= 2'h0;
      sens_flt <= 2'h0;
      rem_flt  <= 1'b0;
    end else begin
      sens_bad <= fail_now;
      // clear only what is valid now
      for (int i = 0; i < esr_pkg::NSENS; i++)
        if (fail_now[i])
          sens_flt[i] <= 1'b1;
        else if (alm_pulse)
          sens_flt[i] <= 1'b0;
      if (rem_bad)
        rem_flt <= 1'b1;
      else if (alm_pulse)
        rem_flt <= 1'b0;
    end
  end

  // Speed, filter and fuel-max outputs stay off and fuel_zero is held on until self-test passes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      speed_ref   <= SPD_ZERO;
      tors_en     <= 1'b0;
      fuel_zero   <= 1'b1;
      fuel_max_ok <= 1'b0;
      rem_active  <= 1'b0;
      ref_state   <= 5'h00;
    end else begin
      speed_ref   <= selftest_ok ? ref_q : SPD_ZERO;
      // any failed sensor drops the filter
      tors_en     <= selftest_ok & cfg_tors_en & ~(|fail_now);
      fuel_zero   <= ~selftest_ok |
                     (&fail_now & ~pin_s[PIN_OVRD]);
      fuel_max_ok <= selftest_ok & (&fail_now) & pin_s[PIN_OVRD];
      rem_active  <= (st == esr_pkg::ST_REMOTE);
      ref_state   <= st;
    end
  end

  // Checks on the design's own behaviour
  property p_fail_set;
    @(posedge clk) disable iff (!nrst)
      fail_now[0] |=> sens_bad[0] ##0 sens_flt[0];
  endproperty
  a_fail_set: assert property (p_fail_set)
    else $error("sensor fail not flagged");

  property p_tors;
    @(posedge clk) disable iff (!nrst)
      (fail_now[0] ^ fail_now[1]) |=> !tors_en;
  endproperty
  a_tors: assert property (p_tors)
    else $error("torsional filter left on");

  property p_fuel;
    @(posedge clk) disable iff (!nrst)
      (&fail_now && selftest_ok) |=>
        (fuel_zero == !$past(pin_s[PIN_OVRD])) && (fuel_max_ok != fuel_zero);
  endproperty
  a_fuel: assert property (p_fuel)
    else $error("both-fail fuel action wrong");

  property p_clear;
    @(posedge clk) disable iff (!nrst)
      (alm_pulse && !fail_now[1] && sens_flt[1]) |=> !sens_flt[1];
  endproperty
  a_clear: assert property (p_clear)
    else $error("valid latch not cleared");

  property p_toggle;
    @(posedge clk) disable iff (!nrst)
      (pin_s[PIN_ALM] ##1 !pin_s[PIN_ALM]) |=> alm_pulse ##1 !alm_pulse;
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("alarm reset toggle lost");

  property p_por;
    @(posedge clk) $rose(nrst) |=> alm_pulse;
  endproperty
  a_por: assert property (p_por)
    else $error("no power-up alarm reset");

  property p_cancel;
    @(posedge clk) disable iff (!nrst)
      (st == esr_pkg::ST_ACCEL && pin_s[PIN_RATED] && loc_raise &&
       !(cfg_start_en && !running)) |=> st == esr_pkg::ST_RATED;
  endproperty
  a_cancel: assert property (p_cancel)
    else $error("accel ramp not cancelled");

  property p_limit;
    @(posedge clk) disable iff (!nrst)
      (st == esr_pkg::ST_REMOTE && next_st == esr_pkg::ST_REMOTE &&
       ref_q >= low_lim && ref_q <= raise_lim && $stable(low_lim) &&
       $stable(raise_lim)) |=> (ref_q >= low_lim && ref_q <= raise_lim);
  endproperty
  a_limit: assert property (p_limit)
    else $error("remote pushed past a limit");

  property p_idle;
    @(posedge clk) disable iff (!nrst)
      (st == esr_pkg::ST_RATED && !pin_s[PIN_RATED] &&
       !(cfg_start_en && !running)) |=> st == esr_pkg::ST_IDLE;
  endproperty
  a_idle: assert property (p_idle)
    else $error("no return to idle");

  property p_remflt;
    @(posedge clk) disable iff (!nrst)
      (ana_en && rem_ua < esr_pkg::UA_FAIL_LO) |=> rem_flt;
  endproperty
  a_remflt: assert property (p_remflt)
    else $error("remote fault missed");

  property p_step;
    @(posedge clk) disable iff (!nrst)
      (!tick && st != esr_pkg::ST_START) |=> $stable(ref_q);
  endproperty
  a_step: assert property (p_step)
    else $error("reference moved off tick");

  c_accel_done: cover property (@(posedge clk) disable iff (!nrst)
    st == esr_pkg::ST_ACCEL ##1 st == esr_pkg::ST_RATED);
  c_remote: cover property (@(posedge clk) disable iff (!nrst)
    st == esr_pkg::ST_RATED ##1 st == esr_pkg::ST_REMOTE);
  c_decel: cover property (@(posedge clk) disable iff (!nrst)
    st == esr_pkg::ST_RATED ##1 st == esr_pkg::ST_IDLE);
  c_start: cover property (@(posedge clk) disable iff (!nrst)
    st == esr_pkg::ST_START ##1 st == esr_pkg::ST_ACCEL);
endmodule : esr_ramp
`default_nettype wire

// ==== sim/esr_field.sv ====
// Field side model: speed sensors, remote loop and reset contact
`timescale 1ns/1ps
`default_nettype none
module esr_field (
  input  wire logic        clk,        // Control clock
  input  wire logic        nrst,       // Sync reset, low
  input  wire logic        alm_req,    // Ask for one reset toggle
  input  wire logic [15:0] a_set,      // Sensor A level to show
  input  wire logic [15:0] b_set,      // Sensor B level to show
  input  wire logic [15:0] ua_set,     // Loop current to show
  output logic             alm_rst_in, // Reset contact
  output logic      [15:0] spd_a,      // Sensor A speed
  output logic      [15:0] spd_b,      // Sensor B speed
  output logic      [15:0] rem_ua      // Loop current, uA
);
  logic [3:0] cnt;  // Toggle phase
  // Sensors and loop settle one cycle after a change
  always_ff @(posedge clk) begin
    spd_a  <= a_set;
    spd_b  <= b_set;
    rem_ua <= ua_set;
  end
  // true then false
  // Held long enough on each level to pass the pin synchroniser
  always_ff @(posedge clk) begin
    if (!nrst)
      cnt <= 4'h0;
    else if (alm_req || cnt != 4'h0)
      cnt <= cnt + 4'h1;
    alm_rst_in <= nrst && cnt >= 4'h1 && cnt <= 4'h5;
  end
endmodule : esr_field
`default_nettype wire

// ==== sim/test_esr_ramp.sv ====
// Self-checking bench for the engine speed reference ramp
`timescale 1ns/1ps
`default_nettype none
module test_esr_ramp;
  typedef struct {int id; logic [15:0] v;} esr_note_s;
  logic clk, nrst, raise_in, lower_in, rated_in, spd_ovrd_in, net_sel_in;
  logic net_link_err, cfg_start_en, cfg_rst_start, cfg_tors_en;
  logic cfg_hold_last, selftest_ok, alm_req, alm_rst_in;
  logic [15:0] spd_a, spd_b, rem_ua, a_set, b_set, ua_set;
  logic [15:0] network_analog_write_value, net_default, start_sp;
  logic [15:0] idle_sp, rated_sp, low_lim, raise_lim, accel_step;
  logic [15:0] decel_step, raise_rate, lower_rate, rem_sp_4ma, rem_sp_20ma;
  logic [15:0] speed_ref, r;
  logic [1:0]  sens_bad, sens_flt;
  logic        rem_flt, tors_en, fuel_zero, fuel_max_ok, alm_pulse;
  logic        rem_active;
  logic [4:0]  ref_state;
  esr_note_s   notes[$];
  esr_note_s   n;
  int          error_cnt, checks, pulses, cycles;
  string nm[10] = '{"speed_ref", "sens_bad", "sens_flt", "rem_flt",
    "tors_en", "fuel_zero", "fuel_max_ok", "rem_active", "ref_state",
    "alarm_pulses"};

  esr_ramp #(.TICK_CYC(4)) u_esr_ramp (.clk, .nrst, .raise_in, .lower_in,
    .rated_in, .alm_rst_in, .spd_ovrd_in, .net_sel_in, .spd_a, .spd_b,
    .rem_ua, .network_analog_write_value, .net_link_err, .cfg_start_en,
    .cfg_rst_start, .cfg_tors_en, .cfg_hold_last, .selftest_ok, .start_sp,
    .idle_sp, .rated_sp, .low_lim, .raise_lim, .accel_step, .decel_step,
    .raise_rate, .lower_rate, .rem_sp_4ma, .rem_sp_20ma, .net_default,
    .speed_ref, .sens_bad, .sens_flt, .rem_flt, .tors_en, .fuel_zero,
    .fuel_max_ok, .alm_pulse, .rem_active, .ref_state);
  esr_field u_esr_field (.clk, .nrst, .alm_req, .a_set, .b_set, .ua_set,
    .alm_rst_in, .spd_a, .spd_b, .rem_ua);

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (error_cnt == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  // Driver side: note what the outputs must show next
  task automatic note(input int id, input logic [15:0] v);
    notes.push_back('{id, v});
  endtask : note

  task automatic cmp(input int id, input logic [15:0] e);
    logic [15:0] s;
    case (id)
      0: s = speed_ref;
      1: s = {14'h0, sens_bad};
      2: s = {14'h0, sens_flt};
      3: s = {15'h0, rem_flt};
      4: s = {15'h0, tors_en};
      5: s = {15'h0, fuel_zero};
      6: s = {15'h0, fuel_max_ok};
      7: s = {15'h0, rem_active};
      8: s = {11'h0, ref_state};
      default: s = pulses[15:0];
    endcase
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm[id], e, s);
    end
  endtask : cmp

  task automatic toggle_reset();
    alm_req = 1'b1;
    cyc(1);
    alm_req = 1'b0;
    cyc(25);
  endtask : toggle_reset

  // Watcher: pulses are counted once each, notes compared oldest first
  always @(negedge clk) begin
    if (alm_pulse === 1'b1) pulses++;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      cmp(n.id, n.v);
    end
  end

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles > 4000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  initial begin
    {nrst, raise_in, lower_in, rated_in, spd_ovrd_in, net_sel_in} = '0;
    {net_link_err, cfg_start_en, cfg_rst_start, cfg_hold_last} = '0;
    {cfg_tors_en, selftest_ok, alm_req} = 3'h6;
    void'($urandom(81437));
    a_set = 16'h0640 + 16'($urandom % 16);
    b_set = 16'h0640;
    ua_set = 16'h4e20;
    network_analog_write_value = 16'h06c0;
    net_default = 16'h0400;
    {start_sp, idle_sp, rated_sp} = {16'h00c8, 16'h0320, 16'h0640};
    {low_lim, raise_lim} = {16'h0500, 16'h0700};
    {accel_step, decel_step} = {16'h0064, 16'h00c8};
    {raise_rate, lower_rate} = {16'h0010, 16'h0020};
    {rem_sp_4ma, rem_sp_20ma} = {16'h0580, 16'h0680};
    cyc(12);
    nrst = 1'b1;
    cyc(5);
    note(9, 16'h0001);
    note(8, 16'h0002);
    cyc(60);
    note(0, 16'h0320);
    rated_in = 1'b1;
    cyc(60);
    note(0, 16'h0640);
    note(8, 16'h0008);
    raise_in = 1'b1;
    cyc(100);
    note(0, 16'h0700);
    raise_in = 1'b0;
    rated_in = 1'b0;
    cyc(60);
    note(0, 16'h0320);
    rated_in = 1'b1;
    cyc(10);
    lower_in = 1'b1;
    cyc(10);
    note(8, 16'h0008);
    lower_in = 1'b0;
    raise_in = 1'b1;
    cyc(300);
    note(0, 16'h0700);
    lower_in = 1'b1;
    cyc(60);
    note(7, 16'h0001);
    note(0, 16'h0680);
    ua_set = 16'h0fa0;
    cyc(60);
    note(0, 16'h0580);
    r = 16'($urandom % 33);
    ua_set = 16'h0fa0 + 16'h01f4 * r;
    cyc(80);
    note(0, 16'h0580 + 16'h0008 * r);
    cfg_hold_last = 1'b1;
    ua_set = 16'h03e8;
    cyc(60);
    note(3, 16'h0001);
    note(0, 16'h0580 + 16'h0008 * r);
    toggle_reset();
    note(3, 16'h0001);
    note(9, 16'h0002);
    ua_set = 16'h4e20;
    toggle_reset();
    note(3, 16'h0000);
    cyc(60);
    note(0, 16'h0680);
    net_sel_in = 1'b1;
    cyc(60);
    note(0, 16'h06c0);
    cfg_hold_last = 1'b0;
    net_link_err = 1'b1;
    cyc(80);
    note(0, 16'h0500);
    note(3, 16'h0001);
    net_link_err = 1'b0;
    {raise_in, lower_in} = 2'h0;
    toggle_reset();
    a_set = 16'h0050;
    cyc(10);
    note(1, 16'h0000);
    a_set = 16'h004f;
    cyc(10);
    note(1, 16'h0001);
    note(4, 16'h0000);
    note(5, 16'h0000);
    b_set = 16'h004f;
    cyc(10);
    note(5, 16'h0001);
    note(6, 16'h0000);
    spd_ovrd_in = 1'b1;
    cyc(10);
    note(5, 16'h0000);
    note(6, 16'h0001);
    {a_set, b_set} = {16'h0640, 16'h0640};
    cyc(10);
    note(2, 16'h0003);
    note(4, 16'h0001);
    toggle_reset();
    note(2, 16'h0000);
    note(9, 16'h0005);
    selftest_ok = 1'b0;
    cyc(10);
    note(0, 16'h0000);
    note(5, 16'h0001);
    selftest_ok = 1'b1;
    cfg_start_en = 1'b1;
    {a_set, b_set} = {16'h0000, 16'h0000};
    cyc(20);
    note(8, 16'h0001);
    note(0, 16'h00c8);
    // Engine starts: startup reset, then ramp from start to rated
    cfg_rst_start = 1'b1;
    {a_set, b_set} = {16'h0640, 16'h0640};
    cyc(80);
    note(9, 16'h0006);
    note(8, 16'h0008);
    note(0, 16'h0640);
    rated_in = 1'b0;
    cyc(40);
    note(8, 16'h0002);
    note(0, 16'h0320);
    // Remote selected in the same cycle as rated closes goes straight to remote
    {raise_in, lower_in, rated_in} = 3'h7;
    cyc(10);
    note(8, 16'h0010);
    note(7, 16'h0001);
    cyc(2);
    tally_and_finish();
  end
endmodule : test_esr_ramp
`default_nettype wire
